/* sswg_defs.svh */
`ifndef SSWG_DEFS_SVH
`define SSWG_DEFS_SVH

// register byte offsets
`define SSWG_PMC_OFF       8'h00
`define SSWG_FWCS_OFF      8'h04
`define SSWG_IFLAG_OFF     8'h08
`define SSWG_PINWAKE_OFF   8'h0C
`define SSWG_STATE_OFF     8'h10

// power_mgmt_control fields
`define SSWG_PMC_READY     0
`define SSWG_PMC_LAN_EN    1
`define SSWG_PMC_ED_EN     2
`define SSWG_PMC_WS_LAN    4
`define SSWG_PMC_WS_ED     5
`define SSWG_PMC_MODE_LO   8
`define SSWG_PMC_MODE_HI   9

// frame_wake_control_status fields
`define SSWG_FWCS_EN_LO    0
`define SSWG_FWCS_EN_HI    4

// pin wake register fields
`define SSWG_PW_EN_HI      10
`define SSWG_PW_LINKUP     16

// reset value and pin count
`define SSWG_MODE_DEFAULT  2'h2
`define SSWG_NPINS         11

`endif

/* sswg_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sswg_host (
	input  wire logic clk_i,
	output logic      suspend_o,
	output logic      resume_o,
	output logic      bus_reset_o,
	output logic      configured_o
);
	initial {suspend_o, resume_o, bus_reset_o, configured_o} = 4'h0;
	// host signaling held for len cycles
	task automatic sig(input logic [2:0] v, input int len);
		@(posedge clk_i);
		{bus_reset_o, resume_o, suspend_o} <= v;
		repeat (len) @(posedge clk_i);
		{bus_reset_o, resume_o, suspend_o} <= 3'h0;
	endtask
	task automatic cfg(input logic v);
		@(posedge clk_i);
		configured_o <= v;
	endtask
endmodule
`default_nettype wire

/* sswg_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sswg_monitor (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       usb_bus_reset_i,
	input wire logic       usb_suspend_i,
	input wire logic       usb_resume_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       remote_wake_o,
	input wire logic       clocks_run_o,
	input wire logic       phy_power_o,
	input wire logic       frame_drop_o,
	input wire logic [2:0] power_state_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	chk_bus_reset: assert property (usb_bus_reset_i |=> power_state_o == 3'h0)
		else $error("bus reset did not give normal");
	chk_suspend_taken: assert property (power_state_o == 3'h0 && usb_suspend_i && !usb_bus_reset_i
		|=> power_state_o != 3'h0) else $error("suspend not taken");
	chk_host_resume: assert property (power_state_o != 3'h0 && usb_resume_i && !usb_bus_reset_i
		|=> power_state_o == 3'h0) else $error("resume did not wake");
	chk_clocks_level3: assert property (clocks_run_o == (power_state_o == 3'h0 || power_state_o == 3'h4))
		else $error("clock run wrong");
	chk_phy_level2: assert property (phy_power_o == (power_state_o != 3'h3))
		else $error("phy power wrong");
	chk_drop_level3: assert property (frame_drop_o |-> power_state_o == 3'h4)
		else $error("frame drop outside level 3");
	chk_wake_pulse: assert property (remote_wake_o |=> !remote_wake_o)
		else $error("remote wake too long");
	chk_wake_normal: assert property (remote_wake_o |-> ##[0:1] power_state_o == 3'h0)
		else $error("remote wake without normal");
	chk_bus_answer: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing wrong");
endmodule
bind sswg_top sswg_monitor u_sswg_monitor (.*);
`default_nettype wire

/* sswg_pkg.sv */
package sswg_pkg;
	typedef enum logic [1:0] {
		SSWG_MODE_L0,
		SSWG_MODE_L1,
		SSWG_MODE_L2,
		SSWG_MODE_L3
	} sswg_mode_type;

	typedef enum logic [2:0] {
		SSWG_NORMAL,
		SSWG_SLEEP0,
		SSWG_SLEEP1,
		SSWG_SLEEP2,
		SSWG_SLEEP3
	} sswg_state_type;
endpackage

/* sswg_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sswg_defs.svh"

// Function
// R1: deconfigure returns sleep level select to 10b
// R2: bus or pin reset gives unconfigured normal
// R3: select 00b suspends into level 0
// R4: select 01b suspends into level 1
// R5: select 10b suspends into level 2, default
// R6: select 11b suspends into level 3 if supported
// R7: level 0 wakes: resume, frame, link, pins
// R8: level 1 wakes: resume, energy, pins only
// R9: level 2 wakes: resume or pins only
// R10: host reinitialises phy after level 2
// R11: level 3 keeps all clocks running
// R12: level 3 wakes: resume, pins, link, good frame
// R13: good frame wake sets frame wake flag
// R14: frame enables in level 3 drop frames
// R15: software reads select to disambiguate frame flag
// R16: link select tells link from pin 7
// R17: good frame needs no frame enables set
// R18: each pin wake sets its own flag
// R19: pending wake at suspend wakes at once
// R20: level 0/1 leave on host resume
// R21: unconfigured suspend enters level 2 only
// R22: ready bit set while in normal state
// R23: permitted wake raises remote wake, returns normal
module sswg_top #(
	parameter bit LEVEL3_SUPPORTED = 1'b1
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        pin_reset_n_i,
	input  wire logic        usb_bus_reset_i,
	input  wire logic        usb_configured_i,
	input  wire logic        usb_suspend_i,
	input  wire logic        usb_resume_i,
	input  wire logic        frame_match_i,
	input  wire logic        filter_pass_i,
	input  wire logic        energy_detect_i,
	input  wire logic        link_up_i,
	input  wire logic [10:0] pin_wake_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             remote_wake_o,
	output logic             clocks_run_o,
	output logic             phy_power_o,
	output logic             frame_drop_o,
	output logic [2:0]       power_state_o
);

	// pin synchronisers
	logic [1:0]  prst_sync_reg;
	logic [10:0] pin_s1_reg;
	logic [10:0] pin_s2_reg;
	logic [10:0] pin_d_reg;
	logic        link_s1_reg;
	logic        link_s2_reg;
	logic        link_d_reg;

	always_ff @(posedge clk_i) begin
		prst_sync_reg <= {prst_sync_reg[0], ~pin_reset_n_i};
	end

	always_ff @(posedge clk_i) begin
		pin_s1_reg <= pin_wake_i;
		pin_s2_reg <= pin_s1_reg;
		pin_d_reg  <= pin_s2_reg;
	end

	always_ff @(posedge clk_i) begin
		link_s1_reg <= link_up_i;
		link_s2_reg <= link_s1_reg;
		link_d_reg  <= link_s2_reg;
	end

	logic hw_reset;
	assign hw_reset = rst_i | usb_bus_reset_i | prst_sync_reg[1]; // R2

	sswg_pkg::sswg_state_type state_reg;
	sswg_pkg::sswg_state_type state_next;
	sswg_pkg::sswg_mode_type  mode_reg;
	logic                     was_unconf_reg;
	logic                     cfg_d_reg;
	logic                     lan_en_reg;
	logic                     ed_en_reg;
	logic                     ws_lan_reg;
	logic                     ws_ed_reg;
	logic [4:0]               frame_en_reg;
	logic [10:0]              pin_en_reg;
	logic                     link_sel_reg;
	logic [10:0]              pin_flag_reg;

	// bus decode
	logic wb_req;
	logic wb_wr;
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// writes land on the edge that sees ack high
	assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	logic wr_pmc;
	logic wr_fwcs;
	logic wr_iflag;
	logic wr_pin;
	assign wr_pmc   = wb_wr && wb_adr_i == `SSWG_PMC_OFF;
	assign wr_fwcs  = wb_wr && wb_adr_i == `SSWG_FWCS_OFF;
	assign wr_iflag = wb_wr && wb_adr_i == `SSWG_IFLAG_OFF;
	assign wr_pin   = wb_wr && wb_adr_i == `SSWG_PINWAKE_OFF;

	// byte lane strobes
	logic wr_pmc_lo;
	logic wr_pmc_mode;
	logic wr_fwcs_lo;
	logic wr_pin_lo;
	logic wr_pin_hi;
	logic wr_pin_link;
	logic wr_iflag_lo;
	logic wr_iflag_hi;
	assign wr_pmc_lo   = wr_pmc & wb_sel_i[0];
	assign wr_pmc_mode = wr_pmc & wb_sel_i[1];
	assign wr_fwcs_lo  = wr_fwcs & wb_sel_i[0];
	assign wr_pin_lo   = wr_pin & wb_sel_i[0];
	assign wr_pin_hi   = wr_pin & wb_sel_i[1];
	assign wr_pin_link = wr_pin & wb_sel_i[2];
	assign wr_iflag_lo = wr_iflag & wb_sel_i[0];
	assign wr_iflag_hi = wr_iflag & wb_sel_i[1];

	// wake sources
	logic        in_normal;
	logic [10:0] pin_evt;
	logic        pin7_link;
	logic        good_frame;
	logic        frame_wake;
	logic        ed_wake;
	logic        link_evt;
	logic        pin_any;
	logic        wake_ok;
	logic        pending;
	logic        in_sleep0;
	logic        in_sleep1;
	logic        in_sleep2;
	logic        in_sleep3;
	logic        link_zone;

	assign in_normal  = state_reg == sswg_pkg::SSWG_NORMAL;
	assign in_sleep0  = state_reg == sswg_pkg::SSWG_SLEEP0;
	assign in_sleep1  = state_reg == sswg_pkg::SSWG_SLEEP1;
	assign in_sleep2  = state_reg == sswg_pkg::SSWG_SLEEP2;
	assign in_sleep3  = state_reg == sswg_pkg::SSWG_SLEEP3;
	// link up counts nowhere in level 1 or 2
	assign link_zone  = ~(in_sleep1 | in_sleep2);
	assign link_evt   = link_s2_reg & ~link_d_reg;
	assign pin7_link  = link_sel_reg & link_evt;
	always_comb begin
		pin_evt = pin_en_reg & pin_s2_reg & ~pin_d_reg;
		pin_evt[7] = link_sel_reg ? (pin7_link & pin_en_reg[7] & link_zone) : pin_evt[7]; // R16
	end
	assign good_frame = filter_pass_i & (frame_en_reg == 5'h00); // R17
	assign frame_wake = frame_match_i & lan_en_reg & (frame_en_reg != 5'h00);
	assign ed_wake    = energy_detect_i & ed_en_reg;
	assign pin_any    = |pin_evt;
	assign pending    = (|pin_flag_reg) | ws_lan_reg | ws_ed_reg;
	assign frame_drop_o = (state_reg == sswg_pkg::SSWG_SLEEP3) && (frame_en_reg != 5'h00); // R14

	always_comb begin
		wake_ok = 1'b0;
		unique case (state_reg)
			sswg_pkg::SSWG_SLEEP0: wake_ok = usb_resume_i | frame_wake | pin7_link | pin_any; // R7 R20
			sswg_pkg::SSWG_SLEEP1: wake_ok = usb_resume_i | ed_wake | pin_any; // R8 R20
			sswg_pkg::SSWG_SLEEP2: wake_ok = usb_resume_i | pin_any; // R9
			sswg_pkg::SSWG_SLEEP3: wake_ok = usb_resume_i | pin_any | pin7_link | good_frame; // R12
			sswg_pkg::SSWG_NORMAL: wake_ok = 1'b0;
			default: wake_ok = 1'b0;
		endcase
	end

	// power state machine
	always_comb begin
		state_next = state_reg;
		if (in_normal) begin
			if (usb_suspend_i) begin
				if (!usb_configured_i) begin
					state_next = sswg_pkg::SSWG_SLEEP2; // R21
				end else begin
					unique case (mode_reg)
						sswg_pkg::SSWG_MODE_L0: state_next = sswg_pkg::SSWG_SLEEP0; // R3
						sswg_pkg::SSWG_MODE_L1: state_next = sswg_pkg::SSWG_SLEEP1; // R4
						sswg_pkg::SSWG_MODE_L2: state_next = sswg_pkg::SSWG_SLEEP2; // R5
						sswg_pkg::SSWG_MODE_L3: state_next = LEVEL3_SUPPORTED ? sswg_pkg::SSWG_SLEEP3
							: sswg_pkg::SSWG_SLEEP2; // R6
					endcase
				end
			end
		end else if (wake_ok || pending) begin
			state_next = sswg_pkg::SSWG_NORMAL; // R19 R23
		end
	end

	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			state_reg <= sswg_pkg::SSWG_NORMAL; // R2
		end else begin
			state_reg <= state_next;
		end
	end

	logic dev_wake;
	// host resume is not a device-caused wake
	assign dev_wake = !in_normal && wake_ok && !usb_resume_i;

	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			remote_wake_o <= 1'b0;
		end else begin
			remote_wake_o <= dev_wake; // R23
		end
	end

	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			was_unconf_reg <= 1'b1;
		end else if (in_normal && usb_suspend_i) begin
			was_unconf_reg <= ~usb_configured_i; // R21
		end
	end

	// configuration and select field
	logic deconfig;
	assign deconfig = cfg_d_reg & ~usb_configured_i;

	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			cfg_d_reg <= 1'b0;
		end else begin
			cfg_d_reg <= usb_configured_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			mode_reg <= sswg_pkg::sswg_mode_type'(`SSWG_MODE_DEFAULT);
		end else if (deconfig) begin
			mode_reg <= sswg_pkg::sswg_mode_type'(`SSWG_MODE_DEFAULT); // R1
		end else if (wr_pmc_mode) begin
			mode_reg <= sswg_pkg::sswg_mode_type'(wb_dat_i[`SSWG_PMC_MODE_HI:`SSWG_PMC_MODE_LO]);
		end
	end

	// lan wake enable
	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			lan_en_reg <= 1'b0;
		end else if (wr_pmc_lo) begin
			lan_en_reg <= wb_dat_i[`SSWG_PMC_LAN_EN];
		end
	end

	// energy detect enable
	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			ed_en_reg <= 1'b0;
		end else if (wr_pmc_lo) begin
			ed_en_reg <= wb_dat_i[`SSWG_PMC_ED_EN];
		end
	end

	// frame match enables
	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			frame_en_reg <= 5'h00;
		end else if (wr_fwcs_lo) begin
			frame_en_reg <= wb_dat_i[`SSWG_FWCS_EN_HI:`SSWG_FWCS_EN_LO];
		end
	end

	// pin wake enables, two lanes
	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			pin_en_reg <= 11'h000;
		end else begin
			if (wr_pin_lo) begin
				pin_en_reg[7:0] <= wb_dat_i[7:0];
			end
			if (wr_pin_hi) begin
				pin_en_reg[10:8] <= wb_dat_i[`SSWG_PW_EN_HI:8];
			end
		end
	end

	// link up select for pin 7
	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			link_sel_reg <= 1'b0;
		end else if (wr_pin_link) begin
			link_sel_reg <= wb_dat_i[`SSWG_PW_LINKUP];
		end
	end

	// sticky wake flags, write one to clear, set wins
	logic        ws_lan_set;
	logic        ws_lan_clr;
	logic        ws_ed_set;
	logic        ws_ed_clr;
	logic [10:0] pin_clr;
	assign ws_lan_set = (in_sleep0 && frame_wake) || (in_sleep3 && good_frame); // R13
	assign ws_lan_clr = wr_pmc_lo && wb_dat_i[`SSWG_PMC_WS_LAN];
	assign ws_ed_set  = in_sleep1 && ed_wake;
	assign ws_ed_clr  = wr_pmc_lo && wb_dat_i[`SSWG_PMC_WS_ED];
	assign pin_clr    = {wr_iflag_hi ? wb_dat_i[10:8] : 3'h0, wr_iflag_lo ? wb_dat_i[7:0] : 8'h00};

	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			ws_lan_reg <= 1'b0;
		end else begin
			ws_lan_reg <= ws_lan_set || (ws_lan_reg && !ws_lan_clr);
		end
	end

	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			ws_ed_reg <= 1'b0;
		end else begin
			ws_ed_reg <= ws_ed_set || (ws_ed_reg && !ws_ed_clr);
		end
	end

	always_ff @(posedge clk_i) begin
		if (hw_reset) begin
			pin_flag_reg <= 11'h000;
		end else begin
			pin_flag_reg <= pin_evt | (pin_flag_reg & ~pin_clr); // R18
		end
	end

	// power outputs
	assign clocks_run_o  = in_normal || state_reg == sswg_pkg::SSWG_SLEEP3; // R11
	assign phy_power_o   = state_reg != sswg_pkg::SSWG_SLEEP2; // R10
	assign power_state_o = state_reg;

	// wishbone read
	logic [31:0] rd_word;
	always_comb begin
		unique case (wb_adr_i)
			`SSWG_PMC_OFF: rd_word = {22'h000000, mode_reg, 2'h0, ws_ed_reg, ws_lan_reg,
				1'b0, ed_en_reg, lan_en_reg, in_normal}; // R22
			`SSWG_FWCS_OFF: rd_word = {27'h0000000, frame_en_reg};
			`SSWG_IFLAG_OFF: rd_word = {21'h000000, pin_flag_reg};
			`SSWG_PINWAKE_OFF: rd_word = {15'h0000, link_sel_reg, 5'h00, pin_en_reg};
			`SSWG_STATE_OFF: rd_word = {28'h0000000, was_unconf_reg, state_reg};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// ack one cycle after the request is taken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	// read data stands for the ack cycle only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req && !wb_we_i) begin
			wb_dat_o <= rd_word;
		end else begin
			wb_dat_o <= 32'h0000_0000;
		end
	end

endmodule
`default_nettype wire

/* test_suspend_state_wake_gating.sv */
`timescale 1ns/1ps
`default_nettype none
module test_suspend_state_wake_gating;
	logic        clk_i = 1'b0, rst_i = 1'b1, pin_reset_n_i = 1'b1;
	logic        frame_match_i = 1'b0, filter_pass_i = 1'b0, energy_detect_i = 1'b0, link_up_i = 1'b0;
	logic [10:0] pin_wake_i = 11'h0;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, exp_q[$];
	logic        wb_ack_o, remote_wake_o, clocks_run_o, phy_power_o, frame_drop_o;
	logic [2:0]  power_state_o;
	wire logic   usb_suspend_i, usb_resume_i, usb_bus_reset_i, usb_configured_i;
	int          mismatches = 0, check_count = 0, p;
	int          wakes = 0, exp_wakes = 0;
	integer      seed = 92372;
	always #50 clk_i = ~clk_i;
	sswg_top u_sswg_top (.*);
	sswg_host u_sswg_host (.clk_i(clk_i), .suspend_o(usb_suspend_i), .resume_o(usb_resume_i),
		.bus_reset_o(usb_bus_reset_i), .configured_o(usb_configured_i));
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		if (!we) exp_q.push_back(d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, we, a, 4'hF};
		wb_dat_i <= we ? d : 32'h0;
		for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
		if (n == 20) begin
			mismatches++;
			results();
		end
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
	endtask
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			cmp("read data", exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD, wb_dat_o);
		end
	end
	always @(posedge clk_i) begin
		if (remote_wake_o === 1'b1) wakes++;
	end
	task automatic state_is(input logic [2:0] e);
		cmp("power state", {29'h0, e}, {29'h0, power_state_o});
	endtask
	task automatic sleep();
		u_sswg_host.sig(3'h1, 1);
		repeat (2) @(posedge clk_i);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, 8'h00, 32'h201);
		bus(0, 8'h20, 32'h0);
		u_sswg_host.cfg(1'b1);
		for (int m = 0; m < 4; m++) begin
			for (int e = 0; e < 3; e++) begin
				bus(1, 8'h04, {31'h0, e == 0});
				bus(1, 8'h00, 32'h36 | (m << 8));
				sleep();
				state_is(m + 1);
				cmp("clocks run", {31'h0, m == 3}, {31'h0, clocks_run_o});
				cmp("phy power", {31'h0, m != 2}, {31'h0, phy_power_o});
				cmp("frame drop", {31'h0, m == 3 && e == 0}, {31'h0, frame_drop_o});
				@(posedge clk_i);
				{frame_match_i, energy_detect_i, filter_pass_i} <= 3'h4 >> e;
				@(posedge clk_i);
				{frame_match_i, energy_detect_i, filter_pass_i} <= 3'h0;
				repeat (6) @(posedge clk_i);
				if ((m == e && m < 2) || (m == 3 && e == 2)) begin
					state_is(0);
					exp_wakes++;
					cmp("remote wakes", exp_wakes, wakes);
					bus(0, 8'h00, 32'h7 | (m << 8) | (e == 1 ? 32'h20 : 32'h10));
				end else begin
					state_is(m + 1);
					u_sswg_host.sig(3'h2, 1);
					repeat (2) @(posedge clk_i);
					state_is(0);
					cmp("remote wakes", exp_wakes, wakes);
				end
			end
		end
		bus(1, 8'h00, 32'h36);
		u_sswg_host.cfg(1'b0);
		bus(0, 8'h00, 32'h207);
		p = $unsigned($random(seed)) % 11;
		bus(1, 8'h0C, 32'h1 << p);
		bus(1, 8'h00, 32'h36);
		sleep();
		state_is(3);
		pin_wake_i <= 11'h1 << p;
		repeat (6) @(posedge clk_i);
		state_is(0);
		exp_wakes++;
		cmp("remote wakes", exp_wakes, wakes);
		bus(0, 8'h08, 32'h1 << p);
		pin_wake_i <= 11'h0;
		bus(1, 8'h08, 32'h7FF);
		sleep();
		state_is(3);
		u_sswg_host.sig(3'h4, 1);
		repeat (2) @(posedge clk_i);
		state_is(0);
		bus(1, 8'h00, 32'h36);
		pin_reset_n_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		pin_reset_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		bus(0, 8'h00, 32'h201);
		results();
	end
endmodule
`default_nettype wire
